// ---- design/scm_clock_manager.v ----
// Clock divider, clock gating, reset cause and sleep control for the manager
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "scm_regs.vh"

module scm_clock_manager #(
	parameter AHB_W  = 7,
	parameter APBA_W = 7,
	parameter APBB_W = 7,
	parameter APBC_W = 17
) (
	input  wire                   CLOCK,
	input  wire                   RST_N,
	input  wire [`SCM_ADDR_W-1:0] ADDR,
	input  wire [31:0]            WDATA,
	input  wire                   WR,
	input  wire                   RD,
	output reg  [31:0]            RDATA,
	input  wire                   WRITE_PROTECT,
	input  wire                   DEBUG_ACCESS,
	input  wire                   POR_RESET,
	input  wire                   CORE_BROWNOUT_RESET,
	input  wire                   IO_BROWNOUT_RESET,
	input  wire                   EXT_RESET_N,
	input  wire                   WDT_RESET,
	input  wire                   SOFTWARE_RESET_REQUEST,
	input  wire                   WAIT_FOR_IRQ_INSTR,
	input  wire                   DEEP_SLEEP_SELECT,
	input  wire                   WAKE_REQUEST,
	input  wire                   DEBUGGER_ATTACHED,
	output wire                   CPU_CLK_EN,
	output wire                   AHB_CLK_EN,
	output wire                   APBA_CLK_EN,
	output wire                   APBB_CLK_EN,
	output wire                   APBC_CLK_EN,
	output wire [AHB_W-1:0]       AHB_GATE_EN,
	output wire [APBA_W-1:0]      APBA_GATE_EN,
	output wire [APBB_W-1:0]      APBB_GATE_EN,
	output wire [APBC_W-1:0]      APBC_GATE_EN,
	output wire                   CLOCK_READY,
	output wire                   IRQ,
	output reg                    POWER_RESET_N,
	output reg                    SYS_RESET_N,
	output reg                    SLEEP_IDLE,
	output reg                    SLEEP_STANDBY,
	output reg                    REGULATOR_LOW_POWER
);

	localparam ST_ACTIVE  = 2'h0;
	localparam ST_IDLE    = 2'h1;
	localparam ST_STANDBY = 2'h2;

	// Mask reset words cut to the configured widths on purpose
	localparam [31:0]       AHB_RST_W  = `SCM_AHB_GATE_MASK_RST;
	localparam [31:0]       APBA_RST_W = `SCM_APBAMASK_RST;
	localparam [31:0]       APBB_RST_W = `SCM_APBBMASK_RST;
	localparam [31:0]       APBC_RST_W = `SCM_APBCMASK_RST;
	localparam [AHB_W-1:0]  AHB_RST    = AHB_RST_W[AHB_W-1:0];
	localparam [APBA_W-1:0] APBA_RST   = APBA_RST_W[APBA_W-1:0];
	localparam [APBB_W-1:0] APBB_RST   = APBB_RST_W[APBB_W-1:0];
	localparam [APBC_W-1:0] APBC_RST   = APBC_RST_W[APBC_W-1:0];

	// True on the last main cycle of each divided period
	function tap_en;
		input [`SCM_PRE_W-1:0] cnt;
		input [`SCM_DIV_W-1:0] div;
		reg   [`SCM_PRE_W-1:0] m;
		begin
			m = ~({`SCM_PRE_W{1'b1}} << div);
			tap_en = ((cnt & m) == m);
		end
	endfunction

	// Write aimed at one register offset
	function wr_at;
		input                   ok;
		input [`SCM_ADDR_W-1:0] a;
		input [`SCM_ADDR_W-1:0] t;
		begin
			wr_at = ok && (a == t);
		end
	endfunction

	// Offsets of the four clock select registers
	function in_sel;
		input [`SCM_ADDR_W-1:0] a;
		begin
			in_sel = (a >= `SCM_CPU_CLOCK_SELECT) && (a <= `SCM_APBCSEL);
		end
	endfunction

	reg [`SCM_PRE_W-1:0]  pre_q;
	reg [`SCM_DIV_W-1:0]  cpu_div_q;
	reg [`SCM_DIV_W-1:0]  apba_div_q;
	reg [`SCM_DIV_W-1:0]  apbb_div_q;
	reg [`SCM_DIV_W-1:0]  apbc_div_q;
	reg [`SCM_DIV_W-1:0]  cpu_new_q;
	reg [`SCM_DIV_W-1:0]  apba_new_q;
	reg [`SCM_DIV_W-1:0]  apbb_new_q;
	reg [`SCM_DIV_W-1:0]  apbc_new_q;
	reg                   pend_q;
	reg                   clock_ready_flag_q;
	reg                   irq_en_q;
	reg [`SCM_IDLE_W-1:0] idle_q;
	reg [AHB_W-1:0]       ahb_mask_q;
	reg [APBA_W-1:0]      apba_mask_q;
	reg [APBB_W-1:0]      apbb_mask_q;
	reg [APBC_W-1:0]      apbc_mask_q;
	reg [`SCM_CAUSE_W-1:0] cause_q;
	reg [1:0]             state_q;
	reg [1:0]             state_d;

	wire [`SCM_CAUSE_W-1:0] src;
	wire power_src;
	wire any_src;
	wire align;
	wire reach;
	wire wr_ok;
	wire wr_prot_ok;
	wire apply;
	wire sleeping;
	wire sel_write;
	wire run_cpu;
	wire run_ahb;
	wire run_apb;

	// Power and user sources gathered into cause bit positions
	assign src[`SCM_CAUSE_POR_BIT] = POR_RESET;
	assign src[`SCM_CAUSE_CBOD]  = CORE_BROWNOUT_RESET;
	assign src[`SCM_CAUSE_IOBOD] = IO_BROWNOUT_RESET;
	assign src[`SCM_CAUSE_SPARE] = 1'b0;
	assign src[`SCM_CAUSE_EXT]   = ~EXT_RESET_N;
	assign src[`SCM_CAUSE_WDT]   = WDT_RESET;
	assign src[`SCM_CAUSE_SOFT]  = SOFTWARE_RESET_REQUEST;
	assign power_src = |src[`SCM_CAUSE_IOBOD:0];
	assign any_src   = |src;

	// Own bus clock gate off makes every register unreachable
	assign reach      = apba_mask_q[`SCM_OWN_GATE_BIT];
	assign wr_ok      = WR & reach;
	// Debugger writes bypass the guard
	assign wr_prot_ok = wr_ok & (~WRITE_PROTECT | DEBUG_ACCESS);

	// Common aligned edge: all taps end a period together
	assign align = (pre_q == `SCM_PRE_ALIGN);
	assign apply = pend_q & align;
	// Any accepted select write restarts the ready handshake
	assign sel_write = wr_prot_ok & in_sel(ADDR);

	// Free-running shared prescaler, never reset by device sources
	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			pre_q <= {`SCM_PRE_W{1'b0}};
		end else begin
			pre_q <= pre_q + 1'b1;
		end
	end

	// Divide settings: staged on write, applied together at alignment
	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			cpu_div_q  <= `SCM_DIV_RST;
			apba_div_q <= `SCM_DIV_RST;
			apbb_div_q <= `SCM_DIV_RST;
			apbc_div_q <= `SCM_DIV_RST;
			cpu_new_q  <= `SCM_DIV_RST;
			apba_new_q <= `SCM_DIV_RST;
			apbb_new_q <= `SCM_DIV_RST;
			apbc_new_q <= `SCM_DIV_RST;
			pend_q     <= 1'b0;
			clock_ready_flag_q    <= 1'b1;
		end else if (any_src) begin
			cpu_div_q  <= `SCM_DIV_RST;
			apba_div_q <= `SCM_DIV_RST;
			apbb_div_q <= `SCM_DIV_RST;
			apbc_div_q <= `SCM_DIV_RST;
			cpu_new_q  <= `SCM_DIV_RST;
			apba_new_q <= `SCM_DIV_RST;
			apbb_new_q <= `SCM_DIV_RST;
			apbc_new_q <= `SCM_DIV_RST;
			pend_q     <= 1'b0;
			clock_ready_flag_q    <= 1'b1;
		end else begin
			// Unwritten domains keep their staged value
			if (wr_at(wr_prot_ok, ADDR, `SCM_CPU_CLOCK_SELECT))
				cpu_new_q <= WDATA[`SCM_DIV_W-1:0];
			if (wr_at(wr_prot_ok, ADDR, `SCM_APBASEL))
				apba_new_q <= WDATA[`SCM_DIV_W-1:0];
			if (wr_at(wr_prot_ok, ADDR, `SCM_APBBSEL))
				apbb_new_q <= WDATA[`SCM_DIV_W-1:0];
			if (wr_at(wr_prot_ok, ADDR, `SCM_APBCSEL))
				apbc_new_q <= WDATA[`SCM_DIV_W-1:0];
			if (sel_write) begin
				pend_q  <= 1'b1;
				clock_ready_flag_q <= 1'b0;
			end else if (apply) begin
				cpu_div_q  <= cpu_new_q;
				apba_div_q <= apba_new_q;
				apbb_div_q <= apbb_new_q;
				apbc_div_q <= apbc_new_q;
				pend_q     <= 1'b0;
				clock_ready_flag_q    <= 1'b1;
			end
		end
	end

	// Clock ready interrupt flag and enable; a set beats a clear write, a select write beats a set
	reg irq_flag_q;
	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			irq_flag_q <= 1'b0;
			irq_en_q   <= 1'b0;
		end else if (any_src) begin
			irq_flag_q <= 1'b0;
			irq_en_q   <= 1'b0;
		end else begin
			// Flag reads zero while a new setting waits, so no stale request
			if (apply && !sel_write)
				irq_flag_q <= 1'b1;
			else if (sel_write)
				irq_flag_q <= 1'b0;
			else if (wr_at(wr_ok, ADDR, `SCM_IRQ_FLAG_REG) && WDATA[`SCM_CLOCK_READY_FLAG_BIT])
				irq_flag_q <= 1'b0;
			if (wr_at(wr_prot_ok, ADDR, `SCM_IRQ_ENABLE_SET) && WDATA[`SCM_CLOCK_READY_FLAG_BIT])
				irq_en_q <= 1'b1;
			else if (wr_at(wr_prot_ok, ADDR, `SCM_IRQ_ENABLE_CLEAR) && WDATA[`SCM_CLOCK_READY_FLAG_BIT])
				irq_en_q <= 1'b0;
		end
	end
	assign IRQ         = irq_flag_q & irq_en_q;
	assign CLOCK_READY = clock_ready_flag_q;

	// Sleep level and peripheral clock masks
	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			idle_q      <= `SCM_IDLE_RST;
			ahb_mask_q  <= AHB_RST;
			apba_mask_q <= APBA_RST;
			apbb_mask_q <= APBB_RST;
			apbc_mask_q <= APBC_RST;
		end else if (any_src) begin
			idle_q      <= `SCM_IDLE_RST;
			ahb_mask_q  <= AHB_RST;
			apba_mask_q <= APBA_RST;
			apbb_mask_q <= APBB_RST;
			apbc_mask_q <= APBC_RST;
		end else if (wr_prot_ok) begin
			case (ADDR)
				`SCM_SLEEP:    idle_q      <= WDATA[`SCM_IDLE_W-1:0];
				`SCM_AHB_GATE_MASK:  ahb_mask_q  <= WDATA[AHB_W-1:0];
				`SCM_APBAMASK: apba_mask_q <= WDATA[APBA_W-1:0];
				`SCM_APBBMASK: apbb_mask_q <= WDATA[APBB_W-1:0];
				`SCM_APBCMASK: apbc_mask_q <= WDATA[APBC_W-1:0];
				default:       idle_q      <= idle_q;
			endcase
		end
	end

	// Latest reset source, replaced on every user reset as well
	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			cause_q <= `SCM_CAUSE_POR;
		end else if (any_src) begin
			cause_q <= src;
		end
	end

	// Device reset outputs, registered to avoid glitches
	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			POWER_RESET_N <= 1'b0;
			SYS_RESET_N   <= 1'b0;
		end else begin
			POWER_RESET_N <= ~power_src;
			SYS_RESET_N   <= ~any_src;
		end
	end

	// Sleep controller
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_ACTIVE:
				if (WAIT_FOR_IRQ_INSTR)
					state_d = DEEP_SLEEP_SELECT ? ST_STANDBY : ST_IDLE;
			ST_IDLE:
				if (WAKE_REQUEST)
					state_d = ST_ACTIVE;
			ST_STANDBY:
				if (WAKE_REQUEST)
					state_d = ST_ACTIVE;
			// Spare code falls back to running
			default:
				state_d = ST_ACTIVE;
		endcase
	end

	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			state_q             <= ST_ACTIVE;
			SLEEP_IDLE          <= 1'b0;
			SLEEP_STANDBY       <= 1'b0;
			REGULATOR_LOW_POWER <= 1'b0;
		end else if (any_src) begin
			state_q             <= ST_ACTIVE;
			SLEEP_IDLE          <= 1'b0;
			SLEEP_STANDBY       <= 1'b0;
			REGULATOR_LOW_POWER <= 1'b0;
		end else begin
			state_q             <= state_d;
			SLEEP_IDLE          <= (state_d == ST_IDLE);
			SLEEP_STANDBY       <= (state_d == ST_STANDBY);
			REGULATOR_LOW_POWER <= (state_d == ST_STANDBY);
		end
	end

	// Domain run decisions; a debugger keeps every clock alive in sleep
	assign sleeping = (state_q != ST_ACTIVE) & ~DEBUGGER_ATTACHED;
	assign run_cpu  = ~sleeping;
	assign run_ahb  = ~sleeping |
		(state_q == ST_IDLE && idle_q == `SCM_IDLE_CPU);
	// Reserved level three behaves like level two
	assign run_apb  = ~sleeping |
		(state_q == ST_IDLE &&
		 (idle_q == `SCM_IDLE_CPU || idle_q == `SCM_IDLE_AHB));

	// Root clock enables: one-cycle pulses at the divided rate
	assign CPU_CLK_EN  = run_cpu & tap_en(pre_q, cpu_div_q);
	assign AHB_CLK_EN  = run_ahb & tap_en(pre_q, cpu_div_q);
	assign APBA_CLK_EN = run_apb & tap_en(pre_q, apba_div_q);
	assign APBB_CLK_EN = run_apb & tap_en(pre_q, apbb_div_q);
	assign APBC_CLK_EN = run_apb & tap_en(pre_q, apbc_div_q);

	// A cleared bit also tells the module its registers are unreachable
	assign AHB_GATE_EN  = {AHB_W{AHB_CLK_EN}} & ahb_mask_q;
	assign APBA_GATE_EN = {APBA_W{APBA_CLK_EN}} & apba_mask_q;
	assign APBB_GATE_EN = {APBB_W{APBB_CLK_EN}} & apbb_mask_q;
	assign APBC_GATE_EN = {APBC_W{APBC_CLK_EN}} & apbc_mask_q;

	// Read port, data one cycle after the strobe; zero when unreachable
	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			RDATA <= 32'h00000000;
		end else begin
			RDATA <= 32'h00000000;
			if (RD && reach) begin
				case (ADDR)
					// Control register has no fields
					`SCM_CTRL:     RDATA <= 32'h00000000;
					`SCM_SLEEP:    RDATA[`SCM_IDLE_W-1:0] <= idle_q;
					`SCM_CPU_CLOCK_SELECT:   RDATA[`SCM_DIV_W-1:0]  <= cpu_new_q;
					`SCM_APBASEL:  RDATA[`SCM_DIV_W-1:0]  <= apba_new_q;
					`SCM_APBBSEL:  RDATA[`SCM_DIV_W-1:0]  <= apbb_new_q;
					`SCM_APBCSEL:  RDATA[`SCM_DIV_W-1:0]  <= apbc_new_q;
					`SCM_IRQ_ENABLE_CLEAR: RDATA[`SCM_CLOCK_READY_FLAG_BIT]  <= irq_en_q;
					`SCM_IRQ_ENABLE_SET: RDATA[`SCM_CLOCK_READY_FLAG_BIT]  <= irq_en_q;
					`SCM_IRQ_FLAG_REG:  RDATA[`SCM_CLOCK_READY_FLAG_BIT]  <= irq_flag_q;
					`SCM_RESET_CAUSE_REG:   RDATA[`SCM_CAUSE_W-1:0] <= cause_q;
					`SCM_AHB_GATE_MASK:  RDATA[AHB_W-1:0]  <= ahb_mask_q;
					`SCM_APBAMASK: RDATA[APBA_W-1:0] <= apba_mask_q;
					`SCM_APBBMASK: RDATA[APBB_W-1:0] <= apbb_mask_q;
					`SCM_APBCMASK: RDATA[APBC_W-1:0] <= apbc_mask_q;
					default:       RDATA <= 32'h00000000;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// ---- design/scm_regs.vh ----
// Register map, field layout and reset constants for the clock, reset and sleep manager
`ifndef SCM_REGS_VH
`define SCM_REGS_VH

`define SCM_ADDR_W        8
`define SCM_CTRL          8'h00
`define SCM_SLEEP         8'h01
`define SCM_CPU_CLOCK_SELECT        8'h08
`define SCM_APBASEL       8'h09
`define SCM_APBBSEL       8'h0A
`define SCM_APBCSEL       8'h0B
`define SCM_IRQ_ENABLE_CLEAR      8'h0C
`define SCM_IRQ_ENABLE_SET      8'h0D
`define SCM_IRQ_FLAG_REG       8'h0E
`define SCM_RESET_CAUSE_REG        8'h0F
`define SCM_AHB_GATE_MASK       8'h14
`define SCM_APBAMASK      8'h18
`define SCM_APBBMASK      8'h1C
`define SCM_APBCMASK      8'h20

`define SCM_DIV_W         3
`define SCM_PRE_W         7
`define SCM_PRE_ALIGN     7'h7F
`define SCM_DIV_RST       3'h0
`define SCM_IDLE_W        2
`define SCM_IDLE_CPU      2'h0
`define SCM_IDLE_AHB      2'h1
`define SCM_IDLE_RST      2'h0
`define SCM_CLOCK_READY_FLAG_BIT     0
`define SCM_OWN_GATE_BIT  1

`define SCM_CAUSE_W       7
`define SCM_CAUSE_POR     7'h01
`define SCM_CAUSE_POR_BIT 0
`define SCM_CAUSE_SPARE   3
`define SCM_CAUSE_CBOD    1
`define SCM_CAUSE_IOBOD   2
`define SCM_CAUSE_EXT     4
`define SCM_CAUSE_WDT     5
`define SCM_CAUSE_SOFT    6

`define SCM_AHB_GATE_MASK_RST   32'h0000007F
`define SCM_APBAMASK_RST  32'h0000007F
`define SCM_APBBMASK_RST  32'h0000007F
`define SCM_APBCMASK_RST  32'h00010000

`endif

// ---- test/scm_props.sv ----
// Port checker for the clock, reset and sleep manager
`timescale 1ns/1ps
`default_nettype none
module scm_props (
	input wire logic       CLOCK,
	input wire logic       RST_N,
	input wire logic [7:0] ADDR,
	input wire logic       WR,
	input wire logic       WRITE_PROTECT,
	input wire logic       DEBUG_ACCESS,
	input wire logic       CLOCK_READY,
	input wire logic       CPU_CLK_EN,
	input wire logic       AHB_CLK_EN,
	input wire logic       APBA_CLK_EN,
	input wire logic       POR_RESET,
	input wire logic       EXT_RESET_N,
	input wire logic       POWER_RESET_N,
	input wire logic       SYS_RESET_N,
	input wire logic       WAIT_FOR_IRQ_INSTR,
	input wire logic       DEEP_SLEEP_SELECT,
	input wire logic       SLEEP_IDLE,
	input wire logic       SLEEP_STANDBY,
	input wire logic       REGULATOR_LOW_POWER,
	input wire logic       DEBUGGER_ATTACHED
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	// Protected select writes are dropped, so they must not clear ready
	wire sel_wr = WR && ADDR >= 8'h08 && ADDR <= 8'h0B && (!WRITE_PROTECT || DEBUG_ACCESS);
	wire stop = (SLEEP_IDLE || SLEEP_STANDBY) && !DEBUGGER_ATTACHED;
	ready_drop_a: assert property (sel_wr |=> !CLOCK_READY)
		else $error("ready kept after select write");
	ready_back_a: assert property (!CLOCK_READY |-> ##[0:140] CLOCK_READY)
		else $error("ready never returned");
	aligned_apply_a: assert property ($rose(CLOCK_READY) |-> $past(CPU_CLK_EN && APBA_CLK_EN))
		else $error("setting applied off the common edge");
	por_reset_a: assert property (POR_RESET |=> !POWER_RESET_N && !SYS_RESET_N)
		else $error("power reset not issued");
	ext_reset_a: assert property (!EXT_RESET_N |=> !SYS_RESET_N)
		else $error("pin reset not issued");
	standby_entry_a: assert property (WAIT_FOR_IRQ_INSTR && DEEP_SLEEP_SELECT && !SLEEP_IDLE
		&& !SLEEP_STANDBY && SYS_RESET_N |=> SLEEP_STANDBY && REGULATOR_LOW_POWER)
		else $error("standby not entered");
	sleep_cpu_a: assert property (stop |-> !CPU_CLK_EN)
		else $error("cpu clock runs in sleep");
	standby_stop_a: assert property (stop && SLEEP_STANDBY |-> !AHB_CLK_EN && !APBA_CLK_EN)
		else $error("bus clock runs in standby");
	cover property (SLEEP_IDLE ##1 !SLEEP_IDLE);
	cover property ($rose(CLOCK_READY));
	cover property (SLEEP_STANDBY && DEBUGGER_ATTACHED && CPU_CLK_EN);
endmodule
bind scm_clock_manager scm_props u_scm_props (.CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR),
	.WR(WR), .WRITE_PROTECT(WRITE_PROTECT), .DEBUG_ACCESS(DEBUG_ACCESS),
	.CLOCK_READY(CLOCK_READY), .CPU_CLK_EN(CPU_CLK_EN), .AHB_CLK_EN(AHB_CLK_EN),
	.APBA_CLK_EN(APBA_CLK_EN), .POR_RESET(POR_RESET), .EXT_RESET_N(EXT_RESET_N),
	.POWER_RESET_N(POWER_RESET_N), .SYS_RESET_N(SYS_RESET_N),
	.WAIT_FOR_IRQ_INSTR(WAIT_FOR_IRQ_INSTR), .DEEP_SLEEP_SELECT(DEEP_SLEEP_SELECT),
	.SLEEP_IDLE(SLEEP_IDLE), .SLEEP_STANDBY(SLEEP_STANDBY),
	.REGULATOR_LOW_POWER(REGULATOR_LOW_POWER), .DEBUGGER_ATTACHED(DEBUGGER_ATTACHED));
`default_nettype wire

// ---- test/scm_periph_model.sv ----
// Clocked peripheral side: counts ticks of each domain
`timescale 1ns/1ps
`default_nettype none
module scm_periph_model (
	input wire logic       clk,
	input wire logic       clear,
	input wire logic       count_en,
	input wire logic       cpu_en,
	input wire logic       ahb_en,
	input wire logic       apb_en,
	output var logic [8:0] cpu_q,
	output var logic [8:0] ahb_q,
	output var logic [8:0] apb_q
);
	// A domain only ticks on an enabled edge, so its count is its rate
	always @(posedge clk) begin
		if (clear) begin
			cpu_q <= 9'h000;
			ahb_q <= 9'h000;
			apb_q <= 9'h000;
		end else if (count_en) begin
			cpu_q <= cpu_q + {8'h00, cpu_en};
			ahb_q <= ahb_q + {8'h00, ahb_en};
			apb_q <= apb_q + {8'h00, apb_en};
		end
	end
endmodule
`default_nettype wire

// ---- test/scm_clock_manager_tb_top.sv ----
// Self-checking bench for the clock, reset and sleep manager
`timescale 1ns/1ps
`default_nettype none
`include "scm_regs.vh"
module scm_clock_manager_tb_top;
	logic        clock = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0, wp = 1'h0, dacc = 1'h0;
	logic        wait_for_irq_instr = 1'h0, deep = 1'h0, wake = 1'h0, dbg = 1'h0, clr = 1'h0, cnt_en = 1'h0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [5:0]  src = 6'h00;
	wire  [31:0] rdata;
	wire         cpu_en, ahb_en, apba_en, ready, irq, pwr_n, sys_n, s_idle, s_stby, reg_lp;
	wire         apbb_en, apbc_en;
	wire  [6:0]  ahb_g, apba_g, apbb_g;
	wire  [16:0] apbc_g;
	wire  [8:0]  cpu_c, ahb_c, apb_c;
	int          n_errors = 0, samples_checked = 0, i;
	logic [7:0]  ma [4] = '{`SCM_AHB_GATE_MASK, `SCM_APBAMASK, `SCM_APBBMASK, `SCM_APBCMASK};
	logic [31:0] mv [4] = '{`SCM_AHB_GATE_MASK_RST, `SCM_APBAMASK_RST, `SCM_APBBMASK_RST,
		`SCM_APBCMASK_RST};
	always #10 clock = ~clock;
	scm_clock_manager u_scm_clock_manager (.CLOCK(clock), .RST_N(rst_n), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .WRITE_PROTECT(wp), .DEBUG_ACCESS(dacc),
		.POR_RESET(src[0]), .CORE_BROWNOUT_RESET(src[1]), .IO_BROWNOUT_RESET(src[2]),
		.EXT_RESET_N(~src[3]), .WDT_RESET(src[4]), .SOFTWARE_RESET_REQUEST(src[5]),
		.WAIT_FOR_IRQ_INSTR(wait_for_irq_instr), .DEEP_SLEEP_SELECT(deep), .WAKE_REQUEST(wake),
		.DEBUGGER_ATTACHED(dbg), .CPU_CLK_EN(cpu_en), .AHB_CLK_EN(ahb_en), .APBA_CLK_EN(apba_en),
		.APBB_CLK_EN(apbb_en), .APBC_CLK_EN(apbc_en), .AHB_GATE_EN(ahb_g),
		.APBA_GATE_EN(apba_g), .APBB_GATE_EN(apbb_g),
		.APBC_GATE_EN(apbc_g), .CLOCK_READY(ready), .IRQ(irq), .POWER_RESET_N(pwr_n),
		.SYS_RESET_N(sys_n), .SLEEP_IDLE(s_idle), .SLEEP_STANDBY(s_stby),
		.REGULATOR_LOW_POWER(reg_lp));
	scm_periph_model u_scm_periph_model (.clk(clock), .clear(clr), .count_en(cnt_en),
		.cpu_en(cpu_en), .ahb_en(ahb_en), .apb_en(apba_en), .cpu_q(cpu_c), .ahb_q(ahb_c),
		.apb_q(apb_c));
	task automatic complete_run;
		if (n_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clock);
		wr <= 1'h0;
		#1;
	endtask
	task automatic rreg(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		addr <= a;
		rd <= 1'h1;
		@(posedge clock);
		rd <= 1'h0;
		#1;
		chk(rdata, e);
	endtask
	task automatic wait_rdy;
		int k;
		for (k = 0; k < 200 && ready !== 1'h1; k++) begin
			@(posedge clock);
			#1;
		end
		if (k == 200) begin
			n_errors++;
			complete_run;
		end
	endtask
	task automatic pulse(input int w);
		@(posedge clock);
		if (w == 0)
			wait_for_irq_instr <= 1'h1;
		else
			wake <= 1'h1;
		@(posedge clock);
		wait_for_irq_instr <= 1'h0;
		wake <= 1'h0;
		#1;
	endtask
	task automatic measure;
		@(posedge clock);
		clr <= 1'h1;
		@(posedge clock);
		clr <= 1'h0;
		cnt_en <= 1'h1;
		repeat (256) @(posedge clock);
		cnt_en <= 1'h0;
		#1;
	endtask
	initial begin
		repeat (16) @(posedge clock);
		rst_n <= 1'h1;
		rreg(`SCM_RESET_CAUSE_REG, `SCM_CAUSE_POR);
		rreg(`SCM_CPU_CLOCK_SELECT, 0);
		chk(ready, 1);
		for (i = 0; i < 4; i++)
			rreg(ma[i], mv[i]);
		chk(apbc_g, `SCM_APBCMASK_RST);
		chk({apba_g, apbb_g}, {7'h7F, 7'h7F});
		wreg(`SCM_AHB_GATE_MASK, 32'h55);
		chk(ahb_g, 7'h55);
		wreg(`SCM_AHB_GATE_MASK, `SCM_AHB_GATE_MASK_RST);
		// APB on the slowest tap keeps the CPU never slower than APB
		wreg(`SCM_APBASEL, 7);
		wait_rdy;
		for (i = 0; i < 8; i++) begin
			wreg(`SCM_CPU_CLOCK_SELECT, i);
			chk(ready, 0);
			wait_rdy;
			rreg(`SCM_CPU_CLOCK_SELECT, i);
			measure;
			chk(cpu_c, 256 >> i);
			chk(ahb_c, 256 >> i);
			chk(apb_c, 2);
		end
		wreg(`SCM_CPU_CLOCK_SELECT, 0);
		wait_rdy;
		wreg(`SCM_IRQ_ENABLE_SET, 1);
		wreg(`SCM_APBASEL, 0);
		chk(irq, 0);
		wait_rdy;
		chk(irq, 1);
		@(posedge clock);
		wp <= 1'h1;
		wreg(`SCM_SLEEP, 2);
		rreg(`SCM_SLEEP, 0);
		wreg(`SCM_IRQ_FLAG_REG, 1);
		chk({ready, irq}, 2);
		@(posedge clock);
		dacc <= 1'h1;
		wreg(`SCM_SLEEP, 2);
		rreg(`SCM_SLEEP, 2);
		wreg(`SCM_APBASEL, 0);
		wait_rdy;
		wreg(`SCM_IRQ_ENABLE_CLEAR, 1);
		chk({ready, irq}, 2);
		wp <= 1'h0;
		dacc <= 1'h0;
		for (i = 0; i < 4; i++) begin
			wreg(`SCM_SLEEP, i);
			pulse(0);
			chk({s_idle, reg_lp, cpu_en}, 4);
			chk({ahb_en, apba_en}, {i == 0, i < 2});
			chk({apbb_en, apbc_en}, {i < 2, i < 2});
			pulse(1);
			chk(s_idle, 0);
		end
		@(posedge clock);
		deep <= 1'h1;
		pulse(0);
		chk({s_stby, reg_lp, cpu_en, ahb_en, apba_en}, 5'h18);
		@(posedge clock);
		dbg <= 1'h1;
		@(posedge clock);
		#1;
		chk({cpu_en, ahb_en, apba_en}, 3'h7);
		dbg <= 1'h0;
		deep <= 1'h0;
		pulse(1);
		chk(s_stby, 0);
		for (i = 0; i < 6; i++) begin
			wreg(`SCM_SLEEP, 1);
			@(posedge clock);
			src <= 6'h01 << i;
			@(posedge clock);
			src <= 6'h00;
			#1;
			chk({pwr_n, sys_n}, {i > 2, 1'h0});
			rreg(`SCM_RESET_CAUSE_REG, i < 3 ? 32'h1 << i : 32'h2 << i);
			rreg(`SCM_SLEEP, 0);
		end
		wreg(`SCM_APBAMASK, 32'h7D);
		chk(apba_g, 7'h7D);
		wreg(`SCM_SLEEP, 1);
		wreg(`SCM_APBAMASK, `SCM_APBAMASK_RST);
		rreg(`SCM_SLEEP, 0);
		pulse(0);
		chk({s_idle, ahb_en}, 2'h3);
		pulse(1);
		chk(apba_g, 7'h7D);
		@(posedge clock);
		rst_n <= 1'h0;
		repeat (2) @(posedge clock);
		rst_n <= 1'h1;
		rreg(`SCM_APBAMASK, `SCM_APBAMASK_RST);
		complete_run;
	end
endmodule
`default_nettype wire
